// ---- core/xmb_pkg.sv ----
// Constants and types shared by the external memory bus files
package xmb_pkg;

  // Oscillator input rate and period
  localparam int OSC_HZ        = 50_000_000;
  localparam int OSC_PERIOD_NS = 20;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Machine cycle: six states, numbered 0 to 5
  localparam int       ST_PER_MC    = 6;
  localparam logic [2:0] ST_FIRST     = 3'h0;
  localparam logic [2:0] ST_HALF_LAST = 3'h2;
  localparam logic [2:0] ST_HALF_B    = 3'h3;
  localparam logic [2:0] ST_LAST      = 3'h5;

  // Position inside a half machine cycle
  localparam logic [1:0] REL_ADDR  = 2'h0;
  localparam logic [1:0] REL_LAST  = 2'h2;

  // Oscillator clocks per state in each clocking mode
  localparam int CLK_PER_ST_12T = 2;
  localparam int CLK_PER_ST_6T  = 1;
  localparam int OSC_PER_MC_12T = ST_PER_MC * CLK_PER_ST_12T;
  localparam int OSC_PER_MC_6T  = ST_PER_MC * CLK_PER_ST_6T;

  // Reset pin must stay high this many machine cycles
  localparam int       RST_HOLD_MC = 2;
  localparam int       RST_CNT_W   = 5;
  localparam logic [RST_CNT_W-1:0] RST_CNT_12T =
    RST_CNT_W'(RST_HOLD_MC * OSC_PER_MC_12T);
  localparam logic [RST_CNT_W-1:0] RST_CNT_6T  =
    RST_CNT_W'(RST_HOLD_MC * OSC_PER_MC_6T);

  // Values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // Kind of bus slot in progress
  typedef enum logic [4:0] {
    SL_NONE = 5'b00001,
    SL_FINT = 5'b00010,
    SL_FEXT = 5'b00100,
    SL_XRD  = 5'b01000,
    SL_XWR  = 5'b10000
  } xmb_slot_e;

  // Power state
  typedef enum logic [2:0] {
    PM_RUN  = 3'b001,
    PM_IDLE = 3'b010,
    PM_DOWN = 3'b100
  } xmb_pm_e;

endpackage

// ---- core/xmb_timing.sv ----
// State and phase generator for the machine cycle
`timescale 1ns/1ps
module xmb_timing (
  input  wire logic       mclk,      // Oscillator clock
  input  wire logic       rst_b,     // Synchronous reset, active low
  input  wire logic       ce,        // Clock enable, freezes all state
  input  wire logic       clr,       // Restart at state 0
  input  wire logic       hold,      // Stop advancing (processor halted)
  input  wire logic       six_mode,  // One clock per state when high
  output logic [2:0]      st,        // Current state 0..5
  output logic            ph,        // Second clock of a state (12T)
  output logic            st_last    // Last clock of the current state
);
  import xmb_pkg::*;

  logic [2:0] st_reg;  // State counter
  logic       ph_reg;  // Phase within state
  logic [2:0] st_next; // Following state

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign st      = st_reg;
  assign ph      = ph_reg;
  assign st_last = six_mode | ph_reg;
  assign st_next = (st_reg == ST_LAST) ? ST_FIRST : st_reg + 3'h1;

  ////////////////////////////////////////////////////////////////////////
  // Counter, frozen by ce so a stopped clock loses nothing
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= ST_FIRST;
      ph_reg <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        st_reg <= ST_FIRST;
        ph_reg <= 1'b0;
      end else if (!hold) begin
        ph_reg <= ~st_last;
        if (st_last) begin
          st_reg <= st_next;
        end
      end
    end
  end

endmodule // xmb_timing

// ---- core/xmb_bus.sv ----
// External program and data memory bus controller of the processor
//
// Function
// - Internal ROM fetch when select high and address in ROM, else bus
// - Program strobe gates external ROM onto bus
// - Latch strobe lets latch take low address
// - Latch strobe at one sixth oscillator rate in 12T, one third in 6T
// - One latch pulse skipped per data access
// - Reset pin high two machine cycles resets
// - Low port carries address then data
// - High port carries upper address byte
// - Write and read strobes for data memory
// - Twelve clocks per cycle, or six configured
// - Idle stops processor clock, peripherals run
// - Power-down stops the oscillator
// - Fully static; clock may stop anytime
`timescale 1ns/1ps
module xmb_bus #(
  parameter int unsigned INT_ROM_BYTES = 65536  // Internal ROM size
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        ce,
  input  wire logic                        six_clock_cycle_mode,
  input  wire logic                        external_access_select,
  input  wire logic                        reset_pin,
  input  wire logic                        idle_req,
  input  wire logic                        powerdown_req,
  input  wire logic                        wake_req,
  output logic                             cpu_clk_en,
  output logic                             periph_clk_en,
  output logic                             osc_en,
  output logic                             dev_reset,
  input  wire logic                        fetch_req,
  input  wire logic [xmb_pkg::ADDR_W-1:0]  fetch_addr,
  input  wire logic [xmb_pkg::DATA_W-1:0]  int_rom_rdata,
  output logic                             fetch_ack,
  output logic                             fetch_rvalid,
  output logic [xmb_pkg::DATA_W-1:0]       fetch_data,
  input  wire logic                        xdata_req,
  input  wire logic                        xdata_we,
  input  wire logic [xmb_pkg::ADDR_W-1:0]  xdata_addr,
  input  wire logic [xmb_pkg::DATA_W-1:0]  xdata_wdata,
  output logic                             xdata_ack,
  output logic                             xdata_rvalid,
  output logic [xmb_pkg::DATA_W-1:0]       xdata_rdata,
  output logic                             ale,
  output logic                             program_store_strobe_b,
  input  wire logic [xmb_pkg::DATA_W-1:0]  ad_in,
  output logic [xmb_pkg::DATA_W-1:0]       ad_out,
  output logic                             ad_oe,
  output logic [xmb_pkg::DATA_W-1:0]       addr_hi_out,
  output logic                             addr_hi_oe,
  output logic                             wr_strobe_b,
  output logic                             rd_strobe_b
);
  import xmb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check
  // The ROM must hold at least one byte and fit the address space
  generate
    if (INT_ROM_BYTES == 0 || INT_ROM_BYTES > (1 << ADDR_W)) begin : g_chk
      $error("INT_ROM_BYTES must lie in 1..65536");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Position of a state inside its half machine cycle
  // States 3..5 fold onto 0..2 so both halves share one decode
  function automatic logic [1:0] rel_of(input logic [2:0] s);
    logic [2:0] r;
    r = (s >= ST_HALF_B) ? s - ST_HALF_B : s;
    return r[1:0];
  endfunction

  // Address falls inside the internal ROM
  // Widened by one bit so a full 64 KiB ROM compares correctly
  function automatic logic in_int_rom(input logic [ADDR_W-1:0] a);
    return {1'b0, a} < 17'(INT_ROM_BYTES);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  xmb_slot_e              slot_reg, slot_next;   // Slot in progress
  xmb_pm_e                pm_reg, pm_next;       // Power state
  logic [ADDR_W-1:0]      addr_reg, addr_next;   // Bus address
  logic [DATA_W-1:0]      wdata_reg;             // Write data
  logic [DATA_W-1:0]      fdata_reg;             // Fetched byte
  logic [DATA_W-1:0]      xrdata_reg;            // Data read byte
  logic                   frv_reg;               // Fetch done pulse
  logic                   xrv_reg;               // Data done pulse
  logic                   mode6_reg;             // Six clock mode held
  logic [RST_CNT_W-1:0]   rcnt_reg;              // Reset pin counter
  logic                   devrst_reg;            // Pin reset active

  // Timing
  logic [2:0]             st;                    // State 0..5
  logic                   ph;                    // Phase in state
  logic                   st_last;               // Last clock of state
  logic [1:0]             rel;                   // Position in half

  // Decoded controls
  logic                   running;               // Processor clocked
  logic                   adv;                   // State ends here
  logic                   end_half;              // Half cycle ends
  logic                   end_mc;                // Machine cycle ends
  logic                   is_fext;               // External fetch slot
  logic                   is_fetch;              // Any fetch slot
  logic                   is_xd;                 // Data slot
  logic                   xcont;                 // Data slot carries on
  logic                   go_idle;               // Enter idle
  logic                   go_pd;                 // Enter power-down
  logic                   take_x;                // Data request taken
  logic                   take_f;                // Fetch request taken
  logic                   fetch_int;             // Fetch from inside
  logic                   f_done;                // Fetch completes
  logic                   x_done;                // Data access completes
  logic [RST_CNT_W-1:0]   rst_thr;               // Reset hold count
  logic                   ale_st;                // State owning a pulse

  ////////////////////////////////////////////////////////////////////////
  // Machine cycle timing
  xmb_timing u_timing (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .clr      (devrst_reg),
    .hold     (~running),
    .six_mode (mode6_reg),
    .st       (st),
    .ph       (ph),
    .st_last  (st_last)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencing decode
  // The processor advances only on the last clock of a state, with ce
  // high and neither idle, power-down nor a pin reset in force
  assign running  = (pm_reg == PM_RUN) & ~devrst_reg;
  assign adv      = ce & running & st_last;
  assign end_half = adv & ((st == ST_HALF_LAST) | (st == ST_LAST));
  assign end_mc   = adv & (st == ST_LAST);
  assign rel      = rel_of(st);
  assign is_fext  = (slot_reg == SL_FEXT);
  assign is_fetch = is_fext | (slot_reg == SL_FINT);
  assign is_xd    = (slot_reg == SL_XRD) | (slot_reg == SL_XWR);
  assign xcont    = is_xd & (st == ST_HALF_LAST);
  assign go_pd    = end_mc & powerdown_req;
  assign go_idle  = end_mc & idle_req & ~powerdown_req;

  // Data access takes a whole machine cycle, fetch a half
  // Power requests are taken first so no slot starts as clocks stop
  // A data request is only taken at a machine cycle boundary
  assign take_x = end_mc & ~go_pd & ~go_idle & xdata_req;
  assign take_f = end_half & ~xcont & ~go_pd & ~go_idle & ~take_x
                & fetch_req;
  assign fetch_int = external_access_select & in_int_rom(fetch_addr);
  assign f_done    = adv & is_fetch & (rel == REL_LAST);
  assign x_done    = end_mc & is_xd;

  // Slot chosen at each half boundary
  // A data slot spans both halves, so its first half end keeps it
  assign slot_next = !end_half ? slot_reg
                   : xcont     ? slot_reg
                   : take_x    ? (xdata_we ? SL_XWR : SL_XRD)
                   : take_f    ? (fetch_int ? SL_FINT : SL_FEXT)
                   :             SL_NONE;
  assign addr_next = take_x ? xdata_addr
                   : take_f ? fetch_addr
                   :          addr_reg;

  // Idle and power-down are entered only at a machine cycle boundary
  // Idle leaves on a wake request; power-down only through a reset
  assign pm_next = go_pd                               ? PM_DOWN
                 : go_idle                             ? PM_IDLE
                 : (pm_reg == PM_IDLE && wake_req)     ? PM_RUN
                 :                                       pm_reg;

  ////////////////////////////////////////////////////////////////////////
  // Requests accepted on the edge the slot starts
  // Combinational, so the requester sees the take before the edge
  assign fetch_ack = take_f;
  assign xdata_ack = take_x;

  ////////////////////////////////////////////////////////////////////////
  // Slot, address and power registers
  always_ff @(posedge mclk) begin
    if (!rst_b || devrst_reg) begin
      slot_reg  <= SL_NONE;
      pm_reg    <= PM_RUN;
      addr_reg  <= ADDR_RST;
      wdata_reg <= DATA_RST;
    end else if (ce) begin
      slot_reg <= slot_next;
      pm_reg   <= pm_next;
      addr_reg <= addr_next;
      if (take_x) begin
        wdata_reg <= xdata_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data capture and completion pulses
  // Completion pulses stand one cycle; data holds until the next
  always_ff @(posedge mclk) begin
    if (!rst_b || devrst_reg) begin
      fdata_reg  <= DATA_RST;
      xrdata_reg <= DATA_RST;
      frv_reg    <= 1'b0;
      xrv_reg    <= 1'b0;
    end else if (ce) begin
      frv_reg <= f_done;
      xrv_reg <= x_done;
      if (f_done) begin
        // Program strobe still low here, ROM data stands on the port
        fdata_reg <= is_fext ? ad_in : int_rom_rdata;
      end
      if (x_done && slot_reg == SL_XRD) begin
        xrdata_reg <= ad_in;
      end
    end
  end

  assign fetch_rvalid = frv_reg;
  assign fetch_data   = fdata_reg;
  assign xdata_rvalid = xrv_reg;
  assign xdata_rdata  = xrdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Reset pin filter: must stay high two machine cycles
  // Counter runs only while ce is high, so a stopped clock does not
  // shorten the hold; a low pin clears it and releases the reset
  assign rst_thr = mode6_reg ? RST_CNT_6T : RST_CNT_12T;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rcnt_reg   <= '0;
      devrst_reg <= 1'b0;
    end else if (ce) begin
      if (!reset_pin) begin
        rcnt_reg   <= '0;
        devrst_reg <= 1'b0;
      end else if (rcnt_reg != rst_thr) begin
        rcnt_reg <= rcnt_reg + 5'h1;
      end else begin
        devrst_reg <= 1'b1;
      end
    end
  end

  assign dev_reset = devrst_reg;

  ////////////////////////////////////////////////////////////////////////
  // Clocking mode captured while any reset is applied
  // Held between resets, so a change on the pin waits for a reset
  always_ff @(posedge mclk) begin
    if (!rst_b || devrst_reg) begin
      mode6_reg <= six_clock_cycle_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock enables for the rest of the chip
  // Peripherals keep running in idle; only power-down stops them
  assign cpu_clk_en    = running;
  assign periph_clk_en = (pm_reg != PM_DOWN);
  assign osc_en        = (pm_reg != PM_DOWN);

  ////////////////////////////////////////////////////////////////////////
  // Pin decode

  // Two pulses per machine cycle; second dropped in a data cycle
  assign ale_st = (st == ST_FIRST) | ((st == ST_HALF_B) & ~is_xd);
  // In 12T the pulse spans the first clock only, so the address
  // still holds one clock after the falling edge for the latch
  assign ale = running & ale_st & (mode6_reg | ~ph);

  // Program strobe low for the two data states of an external fetch
  assign program_store_strobe_b = ~(is_fext & (rel != REL_ADDR));

  // Low port: address in the first state, then data or released
  // In 6T the latch strobe falls as write data replaces the address,
  // so an external latch used in that mode needs no hold time
  assign ad_oe  = (is_fext & (rel == REL_ADDR))
                | (is_xd & (st == ST_FIRST))
                | ((slot_reg == SL_XWR) & (st != ST_FIRST));
  assign ad_out = ((slot_reg == SL_XWR) && (st != ST_FIRST))
                ? wdata_reg : addr_reg[DATA_W-1:0];

  // High port holds upper address throughout an external slot
  // Released for internal fetches and between slots
  assign addr_hi_oe  = is_fext | is_xd;
  assign addr_hi_out = addr_reg[ADDR_W-1:DATA_W];

  // Data memory strobes after the address state
  // Never both low: a slot is either a read or a write
  assign wr_strobe_b = ~((slot_reg == SL_XWR) & (st != ST_FIRST));
  assign rd_strobe_b = ~((slot_reg == SL_XRD) & (st != ST_FIRST));

endmodule // xmb_bus

// ---- tb/xmb_bus_asserts.sv ----
// Port-level timing checks for the external memory bus controller
`timescale 1ns/1ps
module xmb_bus_asserts #(
  parameter int unsigned INT_ROM_BYTES = 65536  // Internal ROM size
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        six_clock_cycle_mode,
  input wire logic        external_access_select,
  input wire logic        reset_pin,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        osc_en,
  input wire logic        dev_reset,
  input wire logic        fetch_ack,
  input wire logic [15:0] fetch_addr,
  input wire logic        fetch_rvalid,
  input wire logic        xdata_ack,
  input wire logic        xdata_rvalid,
  input wire logic        ale,
  input wire logic        program_store_strobe_b,
  input wire logic [7:0]  ad_out,
  input wire logic        ad_oe,
  input wire logic [7:0]  addr_hi_out,
  input wire logic        addr_hi_oe,
  input wire logic        wr_strobe_b,
  input wire logic        rd_strobe_b
);
  // Figures below hold for twelve clocks per machine cycle only
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b || six_clock_cycle_mode);
  logic [15:0] fa_q;  // Fetch address of the taking cycle
  wire ext_f = !external_access_select || 32'(fetch_addr) >= INT_ROM_BYTES;
  always_ff @(posedge mclk) fa_q <= fetch_addr;
  ////////////////////////////////////////////////////////////////////////////
  // Bus walks
  sequence ext_walk_s;
    ad_oe && addr_hi_oe ##2
    (!program_store_strobe_b && !ad_oe)[*4] ##1 program_store_strobe_b;
  endsequence
  sequence int_walk_s;
    (!ad_oe && !addr_hi_oe && program_store_strobe_b)[*6];
  endsequence
  sequence data_ale_s;
    ale ##1 (!ale)[*8];
  endsequence
  ale_one_clk_a: assert property ($rose(ale) |=> (!ale)[*5])
    else $error("latch strobe spacing wrong");
  ale_skip_a: assert property (xdata_ack |=> data_ale_s)
    else $error("latch strobe not skipped in data cycle");
  ext_fetch_a: assert property (fetch_ack && ext_f |=> ext_walk_s)
    else $error("external fetch walk wrong");
  fetch_addr_a: assert property (fetch_ack && ext_f |=>
    {addr_hi_out, ad_out} == fa_q) else $error("fetch address wrong");
  int_fetch_a: assert property (fetch_ack && !ext_f |=> int_walk_s)
    else $error("internal fetch drove the bus");
  fetch_lat_a: assert property (fetch_ack |-> ##7 fetch_rvalid)
    else $error("fetch completion late");
  xdata_lat_a: assert property (xdata_ack |-> ##13 xdata_rvalid)
    else $error("data cycle completion late");
  rd_release_a: assert property (!rd_strobe_b |->
    !ad_oe && wr_strobe_b) else $error("port driven during read");
  wr_drive_a: assert property (!wr_strobe_b |-> ad_oe && rd_strobe_b)
    else $error("port released during write");
  rst_hold_a: assert property ($rose(dev_reset) |->
    $past(reset_pin, 24)) else $error("reset taken too soon");
  idle_quiet_a: assert property (!cpu_clk_en && osc_en |->
    periph_clk_en && !ale) else $error("idle clocks wrong");
  pd_stop_a: assert property (!osc_en |-> !periph_clk_en && !ale)
    else $error("power-down clocks wrong");
endmodule // xmb_bus_asserts

bind xmb_bus xmb_bus_asserts #(.INT_ROM_BYTES(INT_ROM_BYTES)) chk_u (.*);

// ---- tb/xmb_mem_model.sv ----
// External address latch with program and data memory
`timescale 1ns/1ps
module xmb_mem_model (
  input wire logic       mclk,
  input wire logic       ale,
  input wire logic       program_store_strobe_b,
  input wire logic       rd_strobe_b,
  input wire logic       wr_strobe_b,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] addr_hi_out,
  output logic     [7:0] ad_in
);
  logic [7:0] lat_reg;       // Latched low address byte
  logic [7:0] ram [256];     // Data memory, low byte indexed
  initial ad_in = 8'h00;
  // Latch takes the low byte as the strobe falls
  always @(negedge ale) lat_reg <= ad_out;
  // Memory answers one clock after a strobe, else the port value inverts each clock
  always @(posedge mclk) begin
    if (!wr_strobe_b)
      ram[lat_reg] <= ad_out;
    if (!program_store_strobe_b)
      ad_in <= addr_hi_out ^ lat_reg ^ 8'h5a;
    else if (!rd_strobe_b)
      ad_in <= ram[lat_reg];
    else
      ad_in <= ~ad_in;  // Released port: no stale value
  end
endmodule // xmb_mem_model

// ---- tb/xmb_bus_tb.sv ----
// Self-checking bench for the external memory bus controller
`timescale 1ns/1ps
module xmb_bus_tb;
  import xmb_pkg::*;
  localparam int unsigned ROM_N = 256;  // Small internal ROM
  logic mclk = 0, rst_b = 0, ce = 1, six_clock_cycle_mode = 0;
  logic external_access_select = 1, reset_pin = 0;
  logic idle_req = 0, powerdown_req = 0, wake_req = 0;
  logic fetch_req = 0, xdata_req = 0, xdata_we = 0;
  logic [15:0] fetch_addr = 0, xdata_addr = 0;
  logic [7:0]  int_rom_rdata = 0, xdata_wdata = 0, ad_in;
  logic cpu_clk_en, periph_clk_en, osc_en, dev_reset, fetch_ack;
  logic fetch_rvalid, xdata_ack, xdata_rvalid, ale, ad_oe, addr_hi_oe;
  logic program_store_strobe_b, wr_strobe_b, rd_strobe_b, ale_q = 0;
  logic [7:0]  fetch_data, xdata_rdata, ad_out, addr_hi_out, wd [4];
  logic [7:0]  fq [$];           // Expected fetch bytes
  logic [8:0]  dq [$];           // Expected data bytes, bit 8 marks write
  logic [31:0] lf = 32'hcb31ad9b; // Random state
  int num_errors = 0, cmp_count = 0, ale_n = 0, n0, cyc = 0;
  xmb_bus #(.INT_ROM_BYTES(ROM_N)) dut_u (.*);
  xmb_mem_model mem_u (.*);
  always #10 mclk = ~mclk;
  // Internal ROM byte follows the held address
  always @(posedge mclk) int_rom_rdata <= ~fetch_addr[7:0];
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Fetch request held until taken
  task automatic fetch(input logic [15:0] a, input logic ext);
    fq.push_back(ext ? (a[15:8] ^ a[7:0] ^ 8'h5a) : ~a[7:0]);
    @(posedge mclk) fetch_addr <= a;
    fetch_req <= 1'b1;
    do @(negedge mclk); while (fetch_ack !== 1'b1);
    @(posedge mclk) fetch_req <= 1'b0;
  endtask
  // Data memory request held until taken
  task automatic xd(input logic we, input logic [15:0] a, input logic [7:0] d);
    dq.push_back({we, d});
    @(posedge mclk) xdata_we <= we;
    xdata_addr <= a;
    xdata_wdata <= d;
    xdata_req <= 1'b1;
    do @(negedge mclk); while (xdata_ack !== 1'b1);
    @(posedge mclk) xdata_req <= 1'b0;
  endtask
  // Count latch strobe pulses; cut a hang short
  always @(posedge mclk) begin
    ale_q <= ale;
    if (ale && !ale_q) ale_n++;
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Results meet the oldest note
  always @(negedge mclk) begin
    if (fetch_rvalid === 1'b1)
      chk("fetch data", {1'b0, fetch_data}, fq.pop_front());
    if (xdata_rvalid === 1'b1 && !dq[0][8])
      chk("read data", {1'b0, xdata_rdata}, dq[0]);
    if (xdata_rvalid === 1'b1)
      void'(dq.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    fetch(16'h0042, 0);
    repeat (10) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      fetch(lf[15:0] | 16'h0100, 1);
    end
    @(posedge mclk) external_access_select <= 1'b0;
    fetch(16'h0011, 1);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      wd[i] = lf[23:16];
      xd(1, {lf[7:0], 8'(i * 37)}, wd[i]);
    end
    for (int i = 0; i < 4; i++) xd(0, {8'h00, 8'(i * 37)}, wd[i]);
    repeat (20) @(posedge mclk);
    @(negedge mclk) n0 = ale_n;
    repeat (120) @(negedge mclk);
    chk("ale rate", 9'(ale_n - n0), 9'h14);
    @(posedge mclk) idle_req <= 1'b1;
    repeat (14) @(posedge mclk);
    idle_req <= 1'b0;
    @(negedge mclk) n0 = ale_n;
    repeat (24) @(negedge mclk);
    chk("cpu clk", cpu_clk_en, 0);
    chk("periph clk", periph_clk_en, 1);
    chk("idle ale", 9'(ale_n - n0), 0);
    @(posedge mclk) wake_req <= 1'b1;
    @(posedge mclk) wake_req <= 1'b0;
    fetch(16'h0005, 1);
    repeat (10) @(posedge mclk);
    powerdown_req <= 1'b1;
    repeat (14) @(posedge mclk);
    powerdown_req <= 1'b0;
    @(negedge mclk) chk("osc", osc_en, 0);
    @(posedge mclk) reset_pin <= 1'b1;
    repeat (20) @(posedge mclk);
    @(negedge mclk) chk("early reset", dev_reset, 0);
    repeat (8) @(negedge mclk);
    chk("dev reset", dev_reset, 1);
    chk("osc back", osc_en, 1);
    @(posedge mclk) reset_pin <= 1'b0;
    rst_b <= 1'b0;
    six_clock_cycle_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(negedge mclk);
    n0 = ale_n;
    repeat (60) @(negedge mclk);
    chk("six mode ale", 9'(ale_n - n0), 9'h14);
    // Freeze the clock enable in the middle of an external fetch
    fetch(16'h0107, 1);
    @(posedge mclk) ce <= 1'b0;
    @(negedge mclk) n0 = ale_n;
    repeat (6) @(negedge mclk);
    chk("frozen ale", 9'(ale_n - n0), 9'h000);
    @(posedge mclk) ce <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("pending", 9'(fq.size() + dq.size()), 0);
    print_verdict();
  end
endmodule // xmb_bus_tb
